// ==== common/mbpc_pkg.sv ====
// package: constants and types of the bandwidth portion configuration block
// Overview of operation
// - bitmap array of 128 word registers, word n covers portions 32n to 32n+31
// - portion p lives in word p[11:5] at bit p[4:0]
// - bit zero forbids allocation in that portion, bit one allows it
// - bitmap length comes from the reported width, 1 to 4096 bits
// - bits at or beyond the reported width read zero and ignore writes
// - four separate bitmap copies, one per security space, each on its own page
// - with instance select, accesses reach the selected instance and partition
// - bitmap word n decodes at frame offset 0x2000 plus 4n, read/write
// - bitmap words exist only with bandwidth and bitmap support, else read zero
// - root-space copy is read/write only with the realm extension present
// - one 32-bit stride cost register per selected partition, when stride supported
// - stride bit 31 enables stride regulation, bits 30 to 16 read zero
// - stride-minus-one is an unsigned cost, implemented width is the allocation width
package mbpc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned SPACE_W     = 2;
  localparam int unsigned NUM_RIS     = 2;
  localparam int unsigned RIS_W       = 1;
  localparam int unsigned RIS_FLD_W   = 4;
  localparam int unsigned NUM_PART    = 2;
  localparam int unsigned PART_W      = 1;
  localparam int unsigned PART_FLD_W  = 16;
  localparam int unsigned PBM_WORDS   = 128;
  localparam int unsigned PBM_IDX_W   = 7;
  localparam int unsigned MEM_AW      = SPACE_W + RIS_W + PART_W + PBM_IDX_W;
  localparam int unsigned MEM_DEPTH   = 2048;
  localparam int unsigned STR_IDX_W   = SPACE_W + RIS_W + PART_W;
  localparam int unsigned STR_ENTRIES = 16;
  localparam int unsigned STRIDE_MINUS_ONE_W  = 16;
  localparam int unsigned STR_BITS    = STRIDE_MINUS_ONE_W + 1;
  localparam int unsigned STR_RSVD_W  = 15;
  localparam int unsigned PBMW_W      = 13;
  localparam int unsigned BWAW_W      = 5;
  localparam int unsigned PORTION_W   = 12;
  localparam int unsigned BIT_SEL_W   = 5;
  localparam int unsigned OFF_W       = 14;

  // ----------------------------------------------------------------
  // frame offsets and fields
  // ----------------------------------------------------------------
  localparam logic [OFF_W-1:0] BMP_BASE      = 14'h2000;
  localparam logic [OFF_W-1:0] BMP_SPAN_MASK = 14'h01ff;
  localparam logic [OFF_W-1:0] STRIDE_OFF    = 14'h0500;
  localparam int unsigned      IDX_LSB       = 2;
  localparam int unsigned      IDX_MSB       = 8;
  localparam int unsigned      STRIDE_EN_BIT = 31;
  localparam int unsigned      STRIDE_MINUS_ONE_MSB  = 15;
  localparam int unsigned      PORT_WORD_LSB = 5;

  // ----------------------------------------------------------------
  // security spaces and limits
  // ----------------------------------------------------------------
  localparam logic [SPACE_W-1:0]    SP_SECURE  = 2'h0;
  localparam logic [SPACE_W-1:0]    SP_NONSEC  = 2'h1;
  localparam logic [SPACE_W-1:0]    SP_ROOT    = 2'h2;
  localparam logic [SPACE_W-1:0]    SP_REALM   = 2'h3;
  localparam logic [PART_FLD_W-1:0] PART_LIMIT = 16'h0002;
  localparam logic [RIS_FLD_W-1:0]  RIS_LIMIT  = 4'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [STR_BITS-1:0] STRIDE_RST = 17'h00000;
  localparam logic [WORD_W-1:0]   WORD_RST   = 32'h00000000;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                acc_pend;
    logic                                acc_wr;
    logic                                acc_bmp;
    logic [WORD_W-1:0]                   acc_mask;
    logic [WORD_W-1:0]                   rd_hold;
    logic [WORD_W-1:0]                   rdata;
    logic                                ack;
    logic [STR_ENTRIES-1:0][STR_BITS-1:0] stride;
    logic                                qry_pend;
    logic                                qry_ok;
    logic [BIT_SEL_W-1:0]                qry_bit;
    logic [STR_BITS-1:0]                 qs_hold;
    logic                                qvalid;
    logic                                allow;
    logic                                qs_en;
    logic [STRIDE_MINUS_ONE_W-1:0]               qs_m1;
  } mbpc_top_st_t;

  typedef struct packed {
    logic [WORD_W-1:0] a_rdata;
    logic [WORD_W-1:0] b_rdata;
  } mbpc_mem_st_t;

endpackage

// ==== common/mbpc_mem_if.sv ====
// interface: bitmap storage ports between control and memory
`timescale 1ns/100ps
interface mbpc_mem_if;
  import mbpc_pkg::*;

  // access port, read/write
  logic              a_en;
  logic              a_we;
  logic [MEM_AW-1:0] a_addr;
  logic [WORD_W-1:0] a_wdata;
  logic [WORD_W-1:0] a_rdata;
  // lookup port, read only
  logic              b_en;
  logic [MEM_AW-1:0] b_addr;
  logic [WORD_W-1:0] b_rdata;

  modport ctrl (
    output a_en, a_we, a_addr, a_wdata, b_en, b_addr,
    input  a_rdata, b_rdata
  );
  modport mem (
    input  a_en, a_we, a_addr, a_wdata, b_en, b_addr,
    output a_rdata, b_rdata
  );
endinterface

// ==== src/mbpc_bitmap_mem.sv ====
// module: two-port storage of all bitmap words
`timescale 1ns/100ps
module mbpc_bitmap_mem
  import mbpc_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // storage ports
  mbpc_mem_if.mem   mem_port
);

  // ----------------------------------------------------------------
  // storage, one word per space, instance, partition and index
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] bits_mem [MEM_DEPTH];
  mbpc_mem_st_t      st_ff;
  mbpc_mem_st_t      nxt_st;

  always_ff @(posedge clk_in) begin
    if (mem_port.a_en && mem_port.a_we) begin
      bits_mem[mem_port.a_addr] <= mem_port.a_wdata;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    if (mem_port.a_en && !mem_port.a_we) begin
      nxt_st.a_rdata = bits_mem[mem_port.a_addr];
    end
    if (mem_port.b_en) begin
      nxt_st.b_rdata = bits_mem[mem_port.b_addr];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mem_port.a_rdata = st_ff.a_rdata;
  assign mem_port.b_rdata = st_ff.b_rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mem_readback_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (mem_port.a_en && mem_port.a_we)
    ##1 (mem_port.a_en && !mem_port.a_we && mem_port.a_addr == $past(mem_port.a_addr))
    |=> (mem_port.a_rdata == $past(mem_port.a_wdata, 2))
  ) else $error("bitmap word did not read back as written");

endmodule

// ==== src/mbpc_top.sv ====
// module: bandwidth portion bitmap and stride cost configuration
`timescale 1ns/100ps
module mbpc_top
  import mbpc_pkg::*;
(
  // clock and reset
  input  wire logic                                  clk_in,
  input  wire logic                                  nrst_in,
  // frame register access
  input  wire logic                                  acc_req_in,
  input  wire logic                                  acc_wr_in,
  input  wire logic [SPACE_W-1:0]                    acc_space_in,
  input  wire logic [OFF_W-1:0]                      acc_offset_in,
  input  wire logic [WORD_W-1:0]                     acc_wdata_in,
  output logic      [WORD_W-1:0]                     acc_rdata_out,
  output logic                                       acc_ack_out,
  // partition selector contents, one per space
  input  wire logic [3:0][PART_FLD_W-1:0]            selected_partition_field_in,
  input  wire logic [3:0][RIS_FLD_W-1:0]             resource_instance_select_in,
  // feature identification levels
  input  wire logic                                  bw_partitioning_supported_in,
  input  wire logic                                  portion_bitmap_supported_in,
  input  wire logic                                  stride_supported_in,
  input  wire logic                                  instance_select_supported_in,
  input  wire logic                                  realm_extension_present_in,
  input  wire logic [PBMW_W-1:0]                     portion_bitmap_width_in,
  input  wire logic [BWAW_W-1:0]                     bw_alloc_width_in,
  // enforcement lookup
  input  wire logic                                  qry_req_in,
  input  wire logic [SPACE_W-1:0]                    qry_space_in,
  input  wire logic [RIS_FLD_W-1:0]                  qry_ris_in,
  input  wire logic [PART_FLD_W-1:0]                 qry_partition_id_in,
  input  wire logic [PORTION_W-1:0]                  qry_portion_in,
  output logic                                       qry_valid_out,
  output logic                                       qry_allow_out,
  output logic                                       qry_stride_en_out,
  output logic      [STRIDE_MINUS_ONE_W-1:0]                 qry_stride_minus_one_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_n_ff;
  logic rst_n_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_n_ff <= 1'b0;
      rst_n_ff      <= 1'b0;
    end else begin
      rst_meta_n_ff <= 1'b1;
      rst_n_ff      <= rst_meta_n_ff;
    end
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  mbpc_mem_if   mem_bus ();
  mbpc_top_st_t st_ff;
  mbpc_top_st_t nxt_st;

  logic [PART_FLD_W-1:0] a_pid;
  logic [RIS_FLD_W-1:0]  a_ris;
  logic                  a_sel_ok;
  logic                  space_ok;
  logic                  bmp_hit;
  logic                  str_hit;
  logic                  bmp_live;
  logic                  str_live;
  logic [PBM_IDX_W-1:0]  a_idx;
  logic [WORD_W-1:0]     wmask;
  logic [STRIDE_MINUS_ONE_W-1:0] smask;
  logic [STR_IDX_W-1:0]  sidx;
  logic [STR_BITS-1:0]   str_wval;
  logic [WORD_W-1:0]     str_rval;

  assign a_pid    = selected_partition_field_in[acc_space_in];
  assign a_ris    = instance_select_supported_in ? resource_instance_select_in[acc_space_in]
                                                 : '0;
  assign a_sel_ok = (a_pid < PART_LIMIT) && (a_ris < RIS_LIMIT);
  assign space_ok = (acc_space_in != SP_ROOT) || realm_extension_present_in;
  assign bmp_hit  = (acc_offset_in & ~BMP_SPAN_MASK) == BMP_BASE;
  assign str_hit  = {acc_offset_in[OFF_W-1:IDX_LSB], 2'h0} == STRIDE_OFF;
  assign bmp_live = bmp_hit && space_ok && a_sel_ok
                    && bw_partitioning_supported_in && portion_bitmap_supported_in;
  assign str_live = str_hit && space_ok && a_sel_ok
                    && bw_partitioning_supported_in && stride_supported_in;
  assign a_idx    = acc_offset_in[IDX_MSB:IDX_LSB];
  assign sidx     = {acc_space_in, a_ris[RIS_W-1:0], a_pid[PART_W-1:0]};

  // ----------------------------------------------------------------
  // implemented-bit masks
  // ----------------------------------------------------------------
  for (genvar x = 0; x < WORD_W; x++) begin : g_bit
    assign wmask[x] = {1'b0, a_idx, BIT_SEL_W'(x)} < portion_bitmap_width_in;
    if (x < STRIDE_MINUS_ONE_W) begin : g_str
      assign smask[x] = BWAW_W'(x) < bw_alloc_width_in;
    end
  end

  assign str_wval = {acc_wdata_in[STRIDE_EN_BIT],
                     acc_wdata_in[STRIDE_MINUS_ONE_MSB:0] & smask};
  assign str_rval = {st_ff.stride[sidx][STRIDE_MINUS_ONE_W], {STR_RSVD_W{1'b0}},
                     st_ff.stride[sidx][STRIDE_MINUS_ONE_W-1:0]};

  // ----------------------------------------------------------------
  // bitmap storage ports
  // ----------------------------------------------------------------
  assign mem_bus.a_en    = acc_req_in && bmp_live;
  assign mem_bus.a_we    = acc_wr_in;
  assign mem_bus.a_addr  = {acc_space_in, a_ris[RIS_W-1:0], a_pid[PART_W-1:0], a_idx};
  assign mem_bus.a_wdata = acc_wdata_in & wmask;

  mbpc_bitmap_mem u_mem (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_ff),
    .mem_port (mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // lookup decode
  // ----------------------------------------------------------------
  logic [RIS_FLD_W-1:0] q_ris;
  logic                 q_id_ok;
  logic                 q_in_map;
  logic [STR_IDX_W-1:0] q_sidx;

  assign q_ris    = instance_select_supported_in ? qry_ris_in : '0;
  assign q_id_ok  = (qry_partition_id_in < PART_LIMIT) && (q_ris < RIS_LIMIT);
  assign q_in_map = {1'b0, qry_portion_in} < portion_bitmap_width_in;
  assign q_sidx   = {qry_space_in, q_ris[RIS_W-1:0], qry_partition_id_in[PART_W-1:0]};

  assign mem_bus.b_en   = qry_req_in;
  assign mem_bus.b_addr = {qry_space_in, q_ris[RIS_W-1:0], qry_partition_id_in[PART_W-1:0],
                           qry_portion_in[PORTION_W-1:PORT_WORD_LSB]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.acc_pend = acc_req_in;
    nxt_st.acc_wr   = acc_wr_in;
    nxt_st.acc_bmp  = bmp_live;
    nxt_st.acc_mask = bmp_live ? wmask : WORD_RST;
    nxt_st.rd_hold  = str_live ? str_rval : WORD_RST;
    if (acc_req_in && acc_wr_in && str_live) begin
      nxt_st.stride[sidx] = str_wval;
    end
    nxt_st.ack   = st_ff.acc_pend;
    nxt_st.rdata = WORD_RST;
    if (st_ff.acc_pend && !st_ff.acc_wr) begin
      nxt_st.rdata = st_ff.acc_bmp ? (mem_bus.a_rdata & st_ff.acc_mask)
                                   : st_ff.rd_hold;
    end
    nxt_st.qry_pend = qry_req_in;
    nxt_st.qry_bit  = qry_portion_in[BIT_SEL_W-1:0];
    nxt_st.qry_ok   = q_id_ok && q_in_map
                      && bw_partitioning_supported_in && portion_bitmap_supported_in;
    nxt_st.qs_hold  = (q_id_ok && bw_partitioning_supported_in && stride_supported_in)
                      ? st_ff.stride[q_sidx] : STRIDE_RST;
    nxt_st.qvalid   = st_ff.qry_pend;
    nxt_st.allow    = st_ff.qry_pend && st_ff.qry_ok
                      && mem_bus.b_rdata[st_ff.qry_bit];
    nxt_st.qs_en    = st_ff.qry_pend && st_ff.qs_hold[STRIDE_MINUS_ONE_W];
    nxt_st.qs_m1    = st_ff.qry_pend ? st_ff.qs_hold[STRIDE_MINUS_ONE_W-1:0] : '0;
  end

  always_ff @(posedge clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign acc_rdata_out            = st_ff.rdata;
  assign acc_ack_out              = st_ff.ack;
  assign qry_valid_out            = st_ff.qvalid;
  assign qry_allow_out            = st_ff.allow;
  assign qry_stride_en_out        = st_ff.qs_en;
  assign qry_stride_minus_one_out = st_ff.qs_m1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ack_timing_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    acc_req_in |-> ##2 acc_ack_out
  ) else $error("access not answered two cycles after request");

  ack_cause_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    acc_ack_out |-> $past(acc_req_in, 2)
  ) else $error("answer without a request");

  width_mask_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && !acc_wr_in && bmp_hit) |-> ##2 ((acc_rdata_out & ~$past(wmask, 2)) == '0)
  ) else $error("bitmap bit beyond reported width read non-zero");

  absent_bmp_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && bmp_hit && !(bw_partitioning_supported_in && portion_bitmap_supported_in))
    |-> ##2 (acc_rdata_out == '0)
  ) else $error("absent bitmap word read non-zero");

  root_guard_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && acc_space_in == SP_ROOT && !realm_extension_present_in)
    |-> ##2 (acc_rdata_out == '0)
  ) else $error("root space answered without realm extension");

  stride_rsvd_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && !acc_wr_in && str_hit)
    |-> ##2 (acc_rdata_out[STRIDE_EN_BIT-1:STRIDE_MINUS_ONE_W] == '0)
  ) else $error("stride reserved bits read non-zero");

  stride_store_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && acc_wr_in && str_live)
    |=> (st_ff.stride[$past(sidx)] == $past(str_wval))
  ) else $error("stride write not stored for selected partition");

  stride_width_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && !acc_wr_in && str_hit)
    |-> ##2 ((acc_rdata_out[STRIDE_MINUS_ONE_MSB:0] & ~$past(smask, 2)) == '0)
  ) else $error("stride bits beyond allocation width read non-zero");

  qry_timing_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    qry_req_in |-> ##2 qry_valid_out
  ) else $error("lookup not answered two cycles after request");

  qry_forbid_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (qry_req_in && !q_in_map) |-> ##2 !qry_allow_out
  ) else $error("portion beyond bitmap width was allowed");

  unmapped_raz_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_ff)
    (acc_req_in && !bmp_hit && !str_hit) |-> ##2 (acc_rdata_out == '0)
  ) else $error("unmapped offset read non-zero");

endmodule

// ==== bench/mbpc_top_tb_top.sv ====
// testbench: self-checking bench of the bandwidth portion configuration block
`timescale 1ns/100ps
module mbpc_top_tb_top;
  import mbpc_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                            clk_in;
  logic                            nrst_in;
  logic                            acc_req;
  logic                            acc_wr;
  logic [SPACE_W-1:0]              acc_space;
  logic [OFF_W-1:0]                acc_off;
  logic [WORD_W-1:0]               acc_wdata;
  logic [WORD_W-1:0]               acc_rdata;
  logic                            acc_ack;
  logic [3:0][PART_FLD_W-1:0]      sel_part;
  logic [3:0][RIS_FLD_W-1:0]       sel_ris;
  logic                            bw_sup;
  logic                            pbm_sup;
  logic                            str_sup;
  logic                            ris_sup;
  logic                            realm;
  logic [PBMW_W-1:0]               pbm_wd;
  logic [BWAW_W-1:0]               bw_alloc_width;
  logic                            qry_req;
  logic [3:0]                      qry_c;
  logic [PORTION_W-1:0]            qry_portion;
  logic                            qry_valid;
  logic                            qry_allow;
  logic                            qry_en;
  logic [STRIDE_MINUS_ONE_W-1:0]           qry_m1;
  logic [WORD_W-1:0]               mem_exp [16][5];
  logic [WORD_W-1:0]               rd;
  logic [WORD_W-1:0]               str_exp [2];
  int                              error_cnt;
  int                              check_count;
  int                              w;
  int                              n;
  int                              x;
  int                              c;

  mbpc_top mbpc_top_i (
    .clk_in                       (clk_in),
    .nrst_in                      (nrst_in),
    .acc_req_in                   (acc_req),
    .acc_wr_in                    (acc_wr),
    .acc_space_in                 (acc_space),
    .acc_offset_in                (acc_off),
    .acc_wdata_in                 (acc_wdata),
    .acc_rdata_out                (acc_rdata),
    .acc_ack_out                  (acc_ack),
    .selected_partition_field_in  (sel_part),
    .resource_instance_select_in  (sel_ris),
    .bw_partitioning_supported_in (bw_sup),
    .portion_bitmap_supported_in  (pbm_sup),
    .stride_supported_in          (str_sup),
    .instance_select_supported_in (ris_sup),
    .realm_extension_present_in   (realm),
    .portion_bitmap_width_in      (pbm_wd),
    .bw_alloc_width_in            (bw_alloc_width),
    .qry_req_in                   (qry_req),
    .qry_space_in                 (qry_c[3:2]),
    .qry_ris_in                   ({3'h0, qry_c[1]}),
    .qry_partition_id_in          ({15'h0000, qry_c[0]}),
    .qry_portion_in               (qry_portion),
    .qry_valid_out                (qry_valid),
    .qry_allow_out                (qry_allow),
    .qry_stride_en_out            (qry_en),
    .qry_stride_minus_one_out     (qry_m1)
  );

  // ----------------------------------------------------------------
  // clock, expectations, checks
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  function automatic logic [WORD_W-1:0] pbm_mask(input int wn, input int wid);
    logic [WORD_W-1:0] m;
    for (int b = 0; b < 32; b++) m[b] = (32 * wn + b) < wid;
    return m;
  endfunction

  function automatic logic [WORD_W-1:0] stride_exp(input logic [WORD_W-1:0] d, input int bw);
    return {d[31], 15'h0000, d[15:0] & 16'(((32'h1 << bw) - 1))};
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input int cc, input logic [OFF_W-1:0] off,
                     input logic [WORD_W-1:0] wd, output logic [WORD_W-1:0] rdv);
    int i;
    @(posedge clk_in);
    acc_req <= 1'b1;
    acc_wr <= wr;
    acc_space <= cc[3:2];
    acc_off <= off;
    acc_wdata <= wd;
    sel_part[cc[3:2]] <= {15'h0000, cc[0]};
    sel_ris[cc[3:2]] <= {3'h0, cc[1]};
    @(posedge clk_in);
    acc_req <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_in);
      #1;
      if (acc_ack === 1'b1) break;
    end
    rdv = acc_rdata;
    if (i == 4) begin
      error_cnt++;
      results();
    end
    chk("access latency", 32'(i), 32'h0);
  endtask

  task automatic qry(input int cc, input logic [PORTION_W-1:0] p);
    int i;
    @(posedge clk_in);
    qry_req <= 1'b1;
    qry_c <= cc[3:0];
    qry_portion <= p;
    @(posedge clk_in);
    qry_req <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_in);
      #1;
      if (qry_valid === 1'b1) break;
    end
    if (i == 4) begin
      error_cnt++;
      results();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst_in, acc_req, acc_wr, acc_space, acc_off, acc_wdata, qry_req, qry_c, qry_portion} = '0;
    {sel_part, sel_ris, ris_sup} = '0;
    {bw_sup, pbm_sup, str_sup, realm} = 4'hf;
    error_cnt = 0;
    check_count = 0;
    rd = $urandom(68111);
    w = 97 + $urandom % 30;
    pbm_wd = 13'(w);
    bw_alloc_width = 5'h10;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    ris_sup <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("ack after reset", {31'h0, acc_ack}, 32'h0);
    // every space, instance and partition gets its own words
    for (c = 0; c < 16; c++) begin
      for (n = 0; n < 5; n++) begin
        rd = $urandom;
        mem_exp[c][n] = rd & pbm_mask(n, w);
        acc(1'b1, c, BMP_BASE + 14'(4 * n), rd, rd);
      end
    end
    for (c = 0; c < 16; c++) begin
      for (n = 0; n < 5; n++) begin
        acc(1'b0, c, BMP_BASE + 14'(4 * n), 32'h0, rd);
        chk("bitmap word", rd, mem_exp[c][n]);
      end
    end
    for (int k = 0; k < 40; k++) begin
      c = $urandom % 16;
      n = $urandom % 5;
      x = $urandom % 32;
      qry(c, {n[6:0], x[4:0]});
      chk("portion allow", {31'h0, qry_allow}, {31'h0, mem_exp[c][n][x]});
    end
    // without instance select the selector instance is ignored
    ris_sup <= 1'b0;
    acc(1'b0, 4'h7, BMP_BASE + 14'h004, 32'h0, rd);
    chk("instance ignored", rd, mem_exp[5][1]);
    ris_sup <= 1'b1;
    // root frame without the realm extension
    realm <= 1'b0;
    acc(1'b0, 8, BMP_BASE, 32'h0, rd);
    chk("root read", rd, 32'h0);
    acc(1'b1, 8, BMP_BASE, ~mem_exp[8][0], rd);
    realm <= 1'b1;
    acc(1'b0, 8, BMP_BASE, 32'h0, rd);
    chk("root write ignored", rd, mem_exp[8][0]);
    // absent features and unmapped offsets
    bw_sup <= 1'b0;
    acc(1'b0, 0, BMP_BASE, 32'h0, rd);
    chk("no bw support", rd, 32'h0);
    bw_sup <= 1'b1;
    pbm_sup <= 1'b0;
    acc(1'b0, 0, BMP_BASE, 32'h0, rd);
    chk("no bitmap support", rd, 32'h0);
    pbm_sup <= 1'b1;
    acc(1'b0, 0, 14'h2200, 32'h0, rd);
    chk("unmapped read", rd, 32'h0);
    // back-to-back write then read of one word
    @(posedge clk_in);
    acc_req <= 1'b1;
    acc_wr <= 1'b1;
    acc_space <= SP_SECURE;
    acc_off <= BMP_BASE;
    acc_wdata <= ~mem_exp[0][0];
    @(posedge clk_in);
    acc_wr <= 1'b0;
    @(posedge clk_in);
    acc_req <= 1'b0;
    @(posedge clk_in);
    #1;
    chk("read after write", acc_rdata, ~mem_exp[0][0] & pbm_mask(0, w));
    chk("read after write ack", {31'h0, acc_ack}, 32'h1);
    // stride cost register
    bw_alloc_width <= 5'(1 + $urandom % 16);
    for (int k = 0; k < 2; k++) begin
      rd = $urandom;
      str_exp[k] = rd;
      acc(1'b1, k * 15, STRIDE_OFF, rd, rd);
    end
    for (int k = 0; k < 2; k++) begin
      acc(1'b0, k * 15, STRIDE_OFF, 32'h0, rd);
      chk("stride read", rd, stride_exp(str_exp[k], int'(bw_alloc_width)));
      qry(k * 15, 12'h000);
      chk("stride lookup", {qry_en, 15'h0000, qry_m1},
          stride_exp(str_exp[k], int'(bw_alloc_width)));
    end
    str_sup <= 1'b0;
    acc(1'b0, 0, STRIDE_OFF, 32'h0, rd);
    chk("no stride support", rd, 32'h0);
    results();
  end

endmodule
